//--- hdl/ptpce_pkg.sv
/*
 Shared constants and types for the precision time clock with target events.
 Assumes a 32-bit classic Wishbone slave on one 100 MHz clock.
*/
package ptpce_pkg;
	// Register byte addresses
	localparam logic [7:0] A_TIME_VALUE_HIGH = 8'h00;
	localparam logic [7:0] A_TIME_VALUE_LOW = 8'h04;
	localparam logic [7:0] A_RATE_INCREMENT = 8'h08;
	localparam logic [7:0] A_TARGET_VALUE_HIGH = 8'h0c;
	localparam logic [7:0] A_TARGET_VALUE_LOW = 8'h10;
	localparam logic [7:0] A_NEXT_TARGET_HIGH = 8'h14;
	localparam logic [7:0] A_NEXT_TARGET_LOW_OR_PERIOD = 8'h18;
	localparam logic [7:0] A_COMMAND = 8'h1c;
	localparam logic [7:0] A_CONFIG = 8'h20;
	localparam logic [7:0] A_EVENT_STATUS_ENABLE = 8'h24;
	localparam logic [7:0] A_PIN_CONFIG = 8'h28;
	localparam logic [7:0] A_CAPTURE8_HIGH = 8'h2c;
	localparam logic [7:0] A_CAPTURE8_LOW = 8'h30;
	localparam logic [7:0] A_CAPTURE9_HIGH = 8'h34;
	localparam logic [7:0] A_CAPTURE9_LOW = 8'h38;
	localparam logic [7:0] A_SYSTEM_EVENT_STATUS = 8'h3c;
	// Command and flag bit positions
	localparam int CMD_SNAPSHOT = 0;
	localparam int NUM_TS = 6;
	localparam int F_PIN8 = 6;
	localparam int F_TIMER = 8;
	localparam int NUM_FLAGS = 9;
	localparam int EN_LSB = 16;
	// Two-half write groups
	localparam int G_TIME = 0;
	localparam int G_TARGET = 1;
	localparam int G_NEXT = 2;
	localparam int NUM_GROUPS = 3;
	// Reset values
	localparam logic [31:0] RATE_RST = 32'h0000_0000;
	localparam logic [63:0] TIME_RST = 64'h0;
	// Timing
	localparam int CLK_NS = 10;
	localparam int FILTER_NS = 40;
	localparam int PULSE_NS = 100;
	// Strictly longer than the filter time: one extra sample
	localparam int FILTER_CYC = FILTER_NS / CLK_NS + 1;
	localparam int PULSE_CYC = PULSE_NS / CLK_NS;
	// Compare output behaviour per pin
	typedef enum logic [1:0] {OM_PULSE, OM_TOGGLE, OM_FOLLOW, OM_OFF} ptpce_omode_e;
	// Clock configuration word, bit 0 is the reload-or-add select
	typedef struct packed {
		ptpce_omode_e mode9;
		ptpce_omode_e mode8;
		logic [1:0] evt_en;
		logic [1:0] lock;
		logic reload_add;
	} ptpce_cfg_s;
	// Pin configuration word
	typedef struct packed {
		logic [1:0] clr_en;
		logic [1:0] pol;
		logic [1:0] oe;
	} ptpce_gcfg_s;
	localparam ptpce_cfg_s CFG_RST = '{OM_PULSE, OM_PULSE, 2'b00, 2'b00, 1'b0};
	localparam ptpce_gcfg_s GCFG_RST = '{2'b00, 2'b11, 2'b00};
endpackage : ptpce_pkg

//--- hdl/ptpce_top.sv
/*
 Precision time clock, target comparator, pin 8/9 capture and compare outputs,
 event flags and summary bit behind a classic Wishbone slave.
 Assumes pin inputs are asynchronous and time stamp events are one-cycle pulses.
*/
// Design decisions made here: the Wishbone register port and the register offsets.
module ptpce_top import ptpce_pkg::*; #(
	parameter logic [31:0] RATE_INIT = RATE_RST
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [NUM_TS-1:0] TS_EVENT_I,
	input wire logic [1:0] GPIO_I,
	output logic [1:0] GPIO_O,
	output logic [1:0] GPIO_OE,
	output logic SUMMARY_O
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	logic ack_q; // Registered acknowledge
	logic [31:0] dat_q; // Registered read data
	logic [31:0] rdata; // Read mux
	logic wr; // Write commits this edge
	logic [7:0] adr; // Word-aligned address
	logic [31:0] rate_q; // Rate increment
	logic [31:0] acc_q; // Fractional accumulator
	logic [32:0] acc_sum; // Sum with carry
	logic [63:0] time_q; // Time value
	logic [63:0] snap_q; // Snapshot of time
	logic [63:0] tgt_q; // Target value
	logic [63:0] nxt_q; // Next target or period
	logic match_q; // Previous compare result
	logic tgt_evt; // Target compare event
	ptpce_cfg_s cfg_q; // Clock configuration
	ptpce_gcfg_s gcfg_q; // Pin configuration
	logic [NUM_FLAGS-1:0] flag_q; // Sticky event flags
	logic [NUM_FLAGS-1:0] en_q; // Flag enables
	logic [NUM_FLAGS-1:0] flag_set; // Hardware sets
	logic [NUM_FLAGS-1:0] flag_clr; // Clears
	logic [31:0] cfg_wr; // Config word merged with a write
	logic [31:0] gcfg_wr; // Pin config word merged with a write
	logic [31:0] en_wr; // Enable field merged with a write
	logic [31:0] st_hi_q [NUM_GROUPS]; // Staged high halves
	logic [31:0] st_lo_q [NUM_GROUPS]; // Staged low halves
	logic [NUM_GROUPS-1:0] got_hi_q; // High half pending
	logic [NUM_GROUPS-1:0] got_lo_q; // Low half pending
	logic [NUM_GROUPS-1:0] wr_hi; // High half written now
	logic [NUM_GROUPS-1:0] wr_lo; // Low half written now
	logic [NUM_GROUPS-1:0] commit; // Both halves present
	logic [63:0] nval [NUM_GROUPS]; // Value being committed
	logic [1:0] in_ev; // Filtered input edges
	logic [1:0] act_s; // Synchronised active level
	logic [63:0] cap_q [2]; // Pin capture registers
	logic [1:0] out_q; // Pin output flops
	logic [1:0] tog_q; // Toggle levels
	ptpce_omode_e mode [2]; // Per-pin output mode

	assign adr = {WB_ADR_I[7:2], 2'b00};
	assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q;
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;
	assign mode[0] = cfg_q.mode8;
	assign mode[1] = cfg_q.mode9;

	// One wait state; ack drops the cycle after it is given
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
		end
	end

	// Read data sampled in the cycle ack is raised
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			dat_q <= 32'h0;
		end else if (WB_CYC_I & WB_STB_I & ~ack_q & ~WB_WE_I) begin
			dat_q <= rdata;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata = 32'h0;
		unique case (adr)
			A_TIME_VALUE_HIGH: rdata = snap_q[63:32];
			A_TIME_VALUE_LOW: rdata = snap_q[31:0];
			A_RATE_INCREMENT: rdata = rate_q;
			A_TARGET_VALUE_HIGH: rdata = tgt_q[63:32];
			A_TARGET_VALUE_LOW: rdata = tgt_q[31:0];
			A_NEXT_TARGET_HIGH: rdata = nxt_q[63:32];
			A_NEXT_TARGET_LOW_OR_PERIOD: rdata = nxt_q[31:0];
			A_CONFIG: rdata[$bits(cfg_q)-1:0] = cfg_q;
			A_EVENT_STATUS_ENABLE: begin
				rdata[NUM_FLAGS-1:0] = flag_q;
				rdata[EN_LSB +: NUM_FLAGS] = en_q;
			end
			A_PIN_CONFIG: rdata[$bits(gcfg_q)-1:0] = gcfg_q;
			A_CAPTURE8_HIGH: rdata = cap_q[0][63:32];
			A_CAPTURE8_LOW: rdata = cap_q[0][31:0];
			A_CAPTURE9_HIGH: rdata = cap_q[1][63:32];
			A_CAPTURE9_LOW: rdata = cap_q[1][31:0];
			A_SYSTEM_EVENT_STATUS: rdata[0] = SUMMARY_O;
			default: rdata = 32'h0; // Command and holes read zero
		endcase
	end

	// Half-write decode per 64-bit group
	always_comb begin
		wr_hi = '0;
		wr_lo = '0;
		wr_hi[G_TIME] = wr & (adr == A_TIME_VALUE_HIGH);
		wr_lo[G_TIME] = wr & (adr == A_TIME_VALUE_LOW);
		wr_hi[G_TARGET] = wr & (adr == A_TARGET_VALUE_HIGH);
		wr_lo[G_TARGET] = wr & (adr == A_TARGET_VALUE_LOW);
		wr_hi[G_NEXT] = wr & (adr == A_NEXT_TARGET_HIGH);
		wr_lo[G_NEXT] = wr & (adr == A_NEXT_TARGET_LOW_OR_PERIOD);
	end

	// Staging: a group changes only when both halves are in, either order
	for (genvar k = 0; k < NUM_GROUPS; k++) begin : g_stage
		assign commit[k] = (wr_hi[k] | got_hi_q[k]) & (wr_lo[k] | got_lo_q[k]);
		assign nval[k][63:32] = wr_hi[k] ? merge(st_hi_q[k], WB_DAT_I, WB_SEL_I) : st_hi_q[k];
		assign nval[k][31:0] = wr_lo[k] ? merge(st_lo_q[k], WB_DAT_I, WB_SEL_I) : st_lo_q[k];
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				got_hi_q[k] <= 1'b0;
				got_lo_q[k] <= 1'b0;
				st_hi_q[k] <= 32'h0;
				st_lo_q[k] <= 32'h0;
			end else begin
				st_hi_q[k] <= nval[k][63:32];
				st_lo_q[k] <= nval[k][31:0];
				// Pending marks cleared once the pair is used
				got_hi_q[k] <= ~commit[k] & (got_hi_q[k] | wr_hi[k]);
				got_lo_q[k] <= ~commit[k] & (got_lo_q[k] | wr_lo[k]);
			end
		end
	end

	assign cfg_wr = merge(32'(cfg_q), WB_DAT_I, WB_SEL_I);
	assign gcfg_wr = merge(32'(gcfg_q), WB_DAT_I, WB_SEL_I);
	assign en_wr = merge(32'(en_q) << EN_LSB, WB_DAT_I, WB_SEL_I);
	// Plain control registers; unused upper bits are dropped by the slices
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rate_q <= RATE_INIT;
			cfg_q <= CFG_RST;
			gcfg_q <= GCFG_RST;
			en_q <= '0;
		end else if (wr) begin
			unique case (adr)
				A_RATE_INCREMENT: rate_q <= merge(rate_q, WB_DAT_I, WB_SEL_I);
				A_CONFIG: cfg_q <= cfg_wr[$bits(cfg_q)-1:0];
				A_PIN_CONFIG: gcfg_q <= gcfg_wr[$bits(gcfg_q)-1:0];
				A_EVENT_STATUS_ENABLE: en_q <= en_wr[EN_LSB +: NUM_FLAGS];
				default: ;
			endcase
		end
	end

	// Accumulator overflow advances the time; time and accumulator wrap, never saturate
	assign acc_sum = {1'b0, acc_q} + {1'b0, rate_q};
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			acc_q <= 32'h0;
			time_q <= TIME_RST;
		end else begin
			acc_q <= acc_sum[31:0];
			if (commit[G_TIME]) begin
				time_q <= nval[G_TIME];
			end else if (acc_sum[32]) begin
				time_q <= time_q + 64'h1;
			end
		end
	end

	// Snapshot so the two halves read consistently
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			snap_q <= TIME_RST;
		end else if (wr & (adr == A_COMMAND) & WB_SEL_I[0] & WB_DAT_I[CMD_SNAPSHOT]) begin
			snap_q <= time_q;
		end
	end

	// Event on the first cycle of equality; equality holds many cycles
	// because the time only moves on accumulator overflow
	assign tgt_evt = (time_q == tgt_q) & ~match_q;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			match_q <= 1'b0;
		end else begin
			match_q <= time_q == tgt_q;
		end
	end

	// Target retargeting; a host write of both halves wins
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			tgt_q <= 64'h0;
			nxt_q <= 64'h0;
		end else begin
			if (commit[G_NEXT]) begin
				nxt_q <= nval[G_NEXT];
			end
			if (commit[G_TARGET]) begin
				tgt_q <= nval[G_TARGET];
			end else if (tgt_evt & cfg_q.reload_add) begin
				tgt_q <= nxt_q;
			end else if (tgt_evt) begin
				tgt_q <= tgt_q + {32'h0, nxt_q[31:0]};
			end
		end
	end

	// Pin input path: two-flop sync then a length filter
	for (genvar p = 0; p < 2; p++) begin : g_pin_in
		logic [1:0] sync_q; // Bit 0 feeds only bit 1
		logic [3:0] cnt_q; // Consecutive active samples
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				sync_q <= 2'b00;
			end else begin
				sync_q <= {sync_q[0], GPIO_I[p]};
			end
		end
		// Polarity picks the active level, as for the outputs
		assign act_s[p] = sync_q[1] ~^ gcfg_q.pol[p];
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				cnt_q <= 4'h0;
			end else if (!act_s[p]) begin
				cnt_q <= 4'h0; // Short pulses restart the count
			end else if (cnt_q != 4'(FILTER_CYC)) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
		// One pulse per accepted edge, only while configured as input
		assign in_ev[p] = act_s[p] & (cnt_q == 4'(FILTER_CYC - 1)) & ~gcfg_q.oe[p];
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				cap_q[p] <= 64'h0;
			end else if (in_ev[p] & ~(cfg_q.lock[p] & flag_q[F_PIN8 + p])) begin
				cap_q[p] <= time_q;
			end
		end
	end

	// Flag sets and clears; a set always beats a clear
	always_comb begin
		flag_set = {tgt_evt, in_ev, TS_EVENT_I};
		flag_clr = '0;
		if (wr & (adr == A_EVENT_STATUS_ENABLE)) begin
			flag_clr = NUM_FLAGS'(merge(32'h0, WB_DAT_I, WB_SEL_I));
		end
		flag_clr[F_TIMER] = flag_clr[F_TIMER] | |(in_ev & gcfg_q.clr_en);
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			flag_q <= '0;
		end else begin
			flag_q <= (flag_q & ~flag_clr) | flag_set;
		end
	end

	assign SUMMARY_O = |(flag_q & en_q);

	// Compare outputs: pulse counter, toggle level or flag follower
	for (genvar p = 0; p < 2; p++) begin : g_pin_out
		logic [3:0] pcnt_q; // Pulse cycles remaining
		logic fire; // Enabled compare event for this pin
		logic lvl; // Active-high level before polarity
		assign fire = tgt_evt & cfg_q.evt_en[p];
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				pcnt_q <= 4'h0;
			end else if (fire & (mode[p] == OM_PULSE)) begin
				pcnt_q <= 4'(PULSE_CYC);
			end else if (pcnt_q != 4'h0) begin
				pcnt_q <= pcnt_q - 4'h1;
			end
		end
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				tog_q[p] <= 1'b0;
			end else if (fire & (mode[p] == OM_TOGGLE)) begin
				tog_q[p] <= ~tog_q[p];
			end
		end
		always_comb begin
			unique case (mode[p])
				OM_PULSE: lvl = pcnt_q != 4'h0;
				OM_TOGGLE: lvl = tog_q[p];
				OM_FOLLOW: lvl = flag_q[F_TIMER];
				OM_OFF: lvl = 1'b0;
			endcase
		end
		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				out_q[p] <= 1'b0;
			end else begin
				out_q[p] <= lvl ~^ gcfg_q.pol[p];
			end
		end
		// Pulse stays active for at least 8 cycles of its 10-cycle window
		a_pulse_width: assert property (fire && mode[p] == OM_PULSE ##1 1'b1 |=>
			(out_q[p] == gcfg_q.pol[p])[*8])
			else $error("compare pulse too short");
	end

	assign GPIO_O = out_q;
	assign GPIO_OE = gcfg_q.oe; // Drives only when set as output

	a_ack_single: assert property (ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
	a_snapshot_take: assert property (wr && adr == A_COMMAND && WB_SEL_I[0] &&
		WB_DAT_I[CMD_SNAPSHOT] |=> snap_q == $past(time_q))
		else $error("snapshot did not latch time");
	a_time_advance: assert property (acc_sum[32] && !commit[G_TIME] |=>
		time_q == $past(time_q) + 64'h1)
		else $error("time did not advance on overflow");
	a_half_write: assert property (wr_hi[G_TARGET] && !got_lo_q[G_TARGET] &&
		!tgt_evt |=> tgt_q == $past(tgt_q))
		else $error("target changed after one half");
	a_reload_mode: assert property (tgt_evt && cfg_q.reload_add && !commit[G_TARGET]
		|=> tgt_q == $past(nxt_q))
		else $error("reload target wrong");
	a_add_mode: assert property (tgt_evt && !cfg_q.reload_add && !commit[G_TARGET]
		|=> tgt_q == $past(tgt_q) + {32'h0, $past(nxt_q[31:0])})
		else $error("added target wrong");
	a_timer_flag: assert property (tgt_evt |=> flag_q[F_TIMER] &&
		(SUMMARY_O || !en_q[F_TIMER]))
		else $error("target flag or summary missing");
	a_filter_len: assert property (in_ev[0] |-> act_s[0] && $past(act_s[0], 4))
		else $error("short input accepted");
	a_lock_hold: assert property (cfg_q.lock[0] && flag_q[F_PIN8] |=>
		cap_q[0] == $past(cap_q[0]))
		else $error("locked capture overwritten");
	a_clear_wins: assert property (in_ev[0] && gcfg_q.clr_en[0] && !tgt_evt |=>
		!flag_q[F_TIMER])
		else $error("pin edge did not clear target flag");

	c_target_event: cover property (tgt_evt ##1 flag_q[F_TIMER]);
	c_capture: cover property (in_ev[0] ##1 flag_q[F_PIN8]);
	c_time_load: cover property (commit[G_TIME]);
	c_pulse_out: cover property (tgt_evt && cfg_q.evt_en[0]);
endmodule : ptpce_top

//--- verification/ptp_clock_target_events_tb.sv
/*
 Self-checking bench for the precision time clock with target events.
 Assumes the Wishbone slave answers in bounded time and the pin model sits on pins 8 and 9.
*/
module ptp_clock_target_events_tb import ptpce_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench-driven inputs, all valued at time zero
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [NUM_TS-1:0] ts = '0;
	// Design outputs and the pin wire driven by the model
	logic [31:0] dat_o;
	logic ack;
	logic summary;
	logic [1:0] gpio_i;
	logic [1:0] gpio_o;
	logic [1:0] gpio_oe;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	// 100 MHz clock
	always #5 clock = ~clock;
	ptpce_top DUT (.CLOCK(clock), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .TS_EVENT_I(ts), .GPIO_I(gpio_i), .GPIO_O(gpio_o),
		.GPIO_OE(gpio_oe), .SUMMARY_O(summary));
	ptpce_pin_model PINS (.clk(clock), .dev_o(gpio_o), .dev_oe(gpio_oe), .pin_i(gpio_i));
	// Hang guard; the whole run needs well under this
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// One classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		// Ends on ack; only the bench's hang guard stops a wait for a missing ack
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk("ack", 1, ack);
		@(posedge clock);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(what, e, r);
	endtask : rd
	// Low half sits one word above the high half in every pair
	task automatic wr64(input logic [7:0] a, input logic [63:0] v, input bit lo_first);
		if (lo_first) begin
			wr(a + 8'h04, v[31:0]);
			wr(a, v[63:32]);
		end else begin
			wr(a, v[63:32]);
			wr(a + 8'h04, v[31:0]);
		end
	endtask : wr64
	task automatic rd64(input logic [7:0] a, input logic [63:0] e, input string what);
		rd(a, e[63:32], what);
		rd(a + 8'h04, e[31:0], what);
	endtask : rd64
	task automatic snap();
		wr(A_COMMAND, 32'h1 << CMD_SNAPSHOT);
	endtask : snap
	// Reset state; time equals target at release so the target flag is up
	task automatic t_reset();
		rd(A_RATE_INCREMENT, RATE_RST, "rate");
		rd(A_PIN_CONFIG, {26'h0, GCFG_RST}, "pin config");
		rd(8'hfc, 32'h0, "unmapped");
		rd(A_EVENT_STATUS_ENABLE, 32'h100, "reset flags");
		chk("summary masked", 0, summary);
		wr(A_EVENT_STATUS_ENABLE, 32'h100);
	endtask : t_reset
	// Split writes, snapshot hold
	task automatic t_time();
		wr(A_TIME_VALUE_HIGH, 32'h1234_5678);
		snap();
		rd64(A_TIME_VALUE_HIGH, 64'h0, "half written");
		wr(A_TIME_VALUE_LOW, 32'h9abc_def0);
		rd64(A_TIME_VALUE_HIGH, 64'h0, "snapshot held");
		snap();
		rd64(A_TIME_VALUE_HIGH, 64'h1234_5678_9abc_def0, "time");
		wr64(A_TIME_VALUE_HIGH, 64'h1_ffff_fff0, 1'b1);
		snap();
		rd64(A_TIME_VALUE_HIGH, 64'h1_ffff_fff0, "low first");
	endtask : t_time
	// Half rate; low word rolls into the high word
	task automatic t_rate();
		logic [31:0] a;
		logic [31:0] b;
		wr(A_RATE_INCREMENT, 32'h8000_0000);
		snap();
		wb(1'b0, A_TIME_VALUE_LOW, 32'h0, a);
		repeat (100) @(posedge clock);
		snap();
		wb(1'b0, A_TIME_VALUE_LOW, 32'h0, b);
		chk("rate step", 1, (b - a) >= 32'd50 && (b - a) <= 32'd56);
		rd(A_TIME_VALUE_HIGH, 32'h2, "carry");
		wr(A_RATE_INCREMENT, 32'h0);
	endtask : t_rate
	// Add, wrap and reload retargeting
	task automatic t_target();
		wr(A_CONFIG, 32'h0);
		wr64(A_NEXT_TARGET_HIGH, 64'h5, 1'b1);
		wr64(A_TARGET_VALUE_HIGH, 64'h100, 1'b0);
		wr64(A_TIME_VALUE_HIGH, 64'h100, 1'b1);
		rd(A_EVENT_STATUS_ENABLE, 32'h100, "target flag");
		rd64(A_TARGET_VALUE_HIGH, 64'h105, "add");
		wr64(A_TARGET_VALUE_HIGH, 64'hffff_ffff_ffff_fffe, 1'b0);
		wr64(A_TIME_VALUE_HIGH, 64'hffff_ffff_ffff_fffe, 1'b0);
		rd64(A_TARGET_VALUE_HIGH, 64'h3, "wrap");
		wr(A_CONFIG, 32'h1);
		wr64(A_NEXT_TARGET_HIGH, 64'h1_0000_0002, 1'b0);
		wr64(A_TIME_VALUE_HIGH, 64'h3, 1'b0);
		rd64(A_TARGET_VALUE_HIGH, 64'h1_0000_0002, "reload");
		wr(A_TARGET_VALUE_LOW, 32'h7);
		rd64(A_TARGET_VALUE_HIGH, 64'h1_0000_0002, "target half");
		// Finish the pair so no staged low half leaks into later tests
		wr(A_TARGET_VALUE_HIGH, 32'h1);
		rd64(A_TARGET_VALUE_HIGH, 64'h1_0000_0007, "target pair");
		wr(A_EVENT_STATUS_ENABLE, 32'h1ff);
	endtask : t_target
	// Stamp flags, masking, summary and write-one-to-clear
	task automatic t_flags();
		for (int i = 0; i < NUM_TS; i++) begin
			ts <= NUM_TS'(1) << i;
			@(posedge clock);
			ts <= '0;
			@(posedge clock);
			wr(A_EVENT_STATUS_ENABLE, 32'h1 << (EN_LSB + i));
			chk("summary on", 1, summary);
			rd(A_SYSTEM_EVENT_STATUS, 32'h1, "summary reg");
			rd(A_EVENT_STATUS_ENABLE, (32'h1 << (EN_LSB + i)) | (32'h1 << i), "stamp");
			wr(A_EVENT_STATUS_ENABLE, (32'h1 << (EN_LSB + i)) | (32'h1 << i));
			chk("summary off", 0, summary);
		end
		wr(A_EVENT_STATUS_ENABLE, 32'h0);
	endtask : t_flags
	// Pin 8 input: filter, capture, target clear, lock
	task automatic t_pin_in();
		wr(A_PIN_CONFIG, 32'h1c);
		wr64(A_TARGET_VALUE_HIGH, 64'haa_0000_00bb, 1'b0);
		wr64(A_TIME_VALUE_HIGH, 64'haa_0000_00bb, 1'b0);
		PINS.pulse(0, 4);
		repeat (12) @(posedge clock);
		rd(A_EVENT_STATUS_ENABLE, 32'h100, "short pulse");
		PINS.pulse(0, 8);
		repeat (12) @(posedge clock);
		rd(A_EVENT_STATUS_ENABLE, 32'h040, "edge flags");
		rd64(A_CAPTURE8_HIGH, 64'haa_0000_00bb, "capture");
		wr(A_CONFIG, 32'h3);
		wr64(A_TIME_VALUE_HIGH, 64'hcc, 1'b0);
		PINS.pulse(0, 8);
		repeat (12) @(posedge clock);
		rd64(A_CAPTURE8_HIGH, 64'haa_0000_00bb, "locked");
		wr(A_EVENT_STATUS_ENABLE, 32'h040);
		PINS.pulse(0, 8);
		repeat (12) @(posedge clock);
		rd64(A_CAPTURE8_HIGH, 64'hcc, "unlocked");
		wr(A_EVENT_STATUS_ENABLE, 32'h1ff);
	endtask : t_pin_in
	// Compare outputs: pulse width, toggle, follow, polarity
	task automatic t_pin_out();
		ptpce_cfg_s c;
		int n;
		n = 0;
		c = '{OM_TOGGLE, OM_PULSE, 2'b11, 2'b00, 1'b0};
		wr(A_PIN_CONFIG, 32'h07);
		wr(A_CONFIG, {23'h0, c});
		wr64(A_NEXT_TARGET_HIGH, 64'h10, 1'b0);
		wr64(A_TARGET_VALUE_HIGH, 64'h500, 1'b0);
		chk("idle levels", 2'b10, gpio_o);
		chk("drive enable", 2'b11, gpio_oe);
		fork
			wr64(A_TIME_VALUE_HIGH, 64'h500, 1'b0);
			repeat (40) begin
				@(posedge clock);
				if (gpio_o[0] === 1'b1) n++;
			end
		join
		chk("pulse width", PULSE_CYC, n);
		chk("toggled low", 0, gpio_o[1]);
		c.mode8 = OM_FOLLOW;
		wr(A_CONFIG, {23'h0, c});
		wr64(A_TIME_VALUE_HIGH, 64'h510, 1'b0);
		repeat (4) @(posedge clock);
		chk("follow and toggle", 2'b11, gpio_o);
		wr(A_EVENT_STATUS_ENABLE, 32'h100);
		repeat (4) @(posedge clock);
		chk("follow cleared", 0, gpio_o[0]);
		// Off mode ignores the event and the raised flag; pin 9 toggles active low
		c.mode8 = OM_OFF;
		wr(A_CONFIG, {23'h0, c});
		wr64(A_TIME_VALUE_HIGH, 64'h520, 1'b0);
		repeat (4) @(posedge clock);
		chk("off and toggle", 2'b00, gpio_o);
	endtask : t_pin_out
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// Main sequence after 12 reset cycles
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_reset();
		t_time();
		t_rate();
		t_target();
		t_flags();
		t_pin_in();
		t_pin_out();
		end_sim();
	end
endmodule : ptp_clock_target_events_tb

//--- verification/ptpce_pin_model.sv
/*
 Far-side model of pins 8 and 9: the shared wire and an external pulse source.
 Assumes the device drives a pin only while its enable is high; a released wire follows the external driver, low while idle.
*/
module ptpce_pin_model (
	input wire logic clk,
	input wire logic [1:0] dev_o,
	input wire logic [1:0] dev_oe,
	output logic [1:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// External driver level, low while idle
	logic [1:0] ext_q = 2'b00;
	// Wire level; the device wins while it drives the pin
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_i[i] = dev_oe[i] ? dev_o[i] : ext_q[i];
		end
	end
	// Hold one pin active a whole number of cycles, changed only at rising edges
	task automatic pulse(input int pin, input int cyc);
		ext_q[pin] <= 1'b1;
		repeat (cyc) @(posedge clk);
		ext_q[pin] <= 1'b0;
	endtask : pulse
endmodule : ptpce_pin_model
